// >>> logic/rsgc_pad_decode.sv
// Decoder of static pad buffer and pull-up configuration
`timescale 1ns/1ns
module rsgc_pad_decode (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cfg_load,
  input rsgc_pkg::rsgc_pin_cfg_t cfg_in,
  output rsgc_pkg::rsgc_pad_ctl_t ctl_r
);

  logic loaded_r;

  // Buffer type decode
  function automatic rsgc_pkg::rsgc_pad_ctl_t decode(
    input rsgc_pkg::rsgc_pin_cfg_t c);
    rsgc_pkg::rsgc_pad_ctl_t d;
    d.drive_2x = (({c.double_drive_select, c.open_drain_select} ==
      rsgc_pkg::BUF_2X_PP) || ({c.double_drive_select,
      c.open_drain_select} == rsgc_pkg::BUF_2X_OD));
    d.open_drain = (({c.double_drive_select, c.open_drain_select} ==
      rsgc_pkg::BUF_1X_OD) || ({c.double_drive_select,
      c.open_drain_select} == rsgc_pkg::BUF_2X_OD));
    d.pullup_1x = c.weak_pullup_select & ~c.strong_pullup_select;
    d.pullup_2x = c.weak_pullup_select & c.strong_pullup_select;
    return d;
  endfunction : decode

  // Capture the first load after reset, then freeze
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_r <= '0;
      loaded_r <= 1'b0;
    end else if (cfg_load && !loaded_r) begin
      ctl_r <= decode(cfg_in);
      loaded_r <= 1'b1;
    end
  end

  frozen_cfg_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(loaded_r) |-> $stable(ctl_r))
    else $error("pad configuration changed after load");

endmodule : rsgc_pad_decode

// >>> logic/rsgc_pkg.sv
// Package of constants and carrier types for the reset and sleep sequencer
package rsgc_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_PADS = 19;

  // Retention entry after a reset request, in ns (typ and max)
  localparam int RST_RET_TYP_NS = 292;
  localparam int RST_RET_MAX_NS = 376;
  localparam int RST_RET_CYC = RST_RET_TYP_NS / CLK_PERIOD_NS;

  // Retention entry after a sleep request, in ns (typ and max)
  localparam int SLP_RET_TYP_NS = 40;
  localparam int SLP_RET_MAX_NS = 157;
  localparam int SLP_RET_CYC = SLP_RET_TYP_NS / CLK_PERIOD_NS;

  // Exit from reset and from sleep, in ns (typ and max)
  localparam int RST_EXIT_TYP_NS = 215_500;
  localparam int RST_EXIT_MAX_NS = 310_000;
  localparam int RST_EXIT_CYC = RST_EXIT_TYP_NS / CLK_PERIOD_NS;
  localparam int SLP_EXIT_TYP_NS = 149_000;
  localparam int SLP_EXIT_MAX_NS = 225_000;
  localparam int SLP_EXIT_CYC = SLP_EXIT_TYP_NS / CLK_PERIOD_NS;

  // Least low time the far side must keep on either pin, in ns
  localparam int PIN_LOW_MIN_NS = 500_000;

  // User clock stop limit, in ns, and cycles
  localparam int CLK_STOP_MAX_NS = 5_000;
  localparam int CLK_STOP_CYC = CLK_STOP_MAX_NS / CLK_PERIOD_NS;

  // Oscillator settling time, in ns (plain default)
  localparam int OSC_SETTLE_NS = 1_000;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_NS / CLK_PERIOD_NS;

  // Slow clock periods that entry also waits out, up to the clock stop limit
  localparam int SLOW_CLK_PERIODS = 2;

  // Counter width
  localparam int CNT_W = 16;

  // Output buffer encodings {double_drive_select, open_drain_select}
  localparam logic [1:0] BUF_1X_PP = 2'h0;
  localparam logic [1:0] BUF_1X_OD = 2'h1;
  localparam logic [1:0] BUF_2X_PP = 2'h2;
  localparam logic [1:0] BUF_2X_OD = 2'h3;

  // Static per-pin configuration
  typedef struct packed {
    logic double_drive_select;
    logic open_drain_select;
    logic weak_pullup_select;
    logic strong_pullup_select;
  } rsgc_pin_cfg_t;

  // Resolved pad controls
  typedef struct packed {
    logic drive_2x;
    logic open_drain;
    logic pullup_1x;
    logic pullup_2x;
  } rsgc_pad_ctl_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_FUNC, ST_STOP, ST_RET, ST_EXIT
  } rsgc_state_t;

endpackage : rsgc_pkg

// >>> logic/rsgc_seq.sv
// Reset and sleep sequencer with pad retention and user clock gating
`timescale 1ns/1ns
module rsgc_seq (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic chip_reset_pin_low,
  input wire logic sleep_pin_low,
  input wire logic fabric_reset_req,
  input wire logic fabric_sleep_req,
  input wire logic oscillator_on,
  input wire logic slow_clk_tick,
  input wire logic slow_clk_used,
  input wire logic cfg_load,
  input rsgc_pkg::rsgc_pin_cfg_t pin_cfg [rsgc_pkg::NUM_PADS],
  input wire logic [rsgc_pkg::NUM_PADS-1:0] user_out,
  input wire logic [rsgc_pkg::NUM_PADS-1:0] user_oe_n,
  output logic [rsgc_pkg::NUM_PADS-1:0] output_pads_r,
  output logic [rsgc_pkg::NUM_PADS-1:0] output_pads_oe_n_r,
  output rsgc_pkg::rsgc_pad_ctl_t pad_ctl_r [rsgc_pkg::NUM_PADS],
  output logic retention_r,
  output logic user_clk_en_r,
  output logic config_start_r,
  output logic functional_r
);

  rsgc_pkg::rsgc_state_t state_r;
  logic [rsgc_pkg::CNT_W-1:0] cnt_r;
  logic [1:0] slow_cnt_r;
  logic is_reset_r;
  logic rst_pin_d_r;
  logic slp_pin_d_r;
  logic rst_req;
  logic slp_req;
  logic [rsgc_pkg::CNT_W-1:0] entry_cyc;

  ////////////////////////////////////////////////////////////////////////
  // Request detection

  // Falling pins or fabric requests start entry
  assign rst_req = (!chip_reset_pin_low && rst_pin_d_r)
                   || fabric_reset_req;
  assign slp_req = (!sleep_pin_low && slp_pin_d_r)
                   || fabric_sleep_req;

  // Pin history
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rst_pin_d_r <= 1'b1;
      slp_pin_d_r <= 1'b1;
    end else begin
      rst_pin_d_r <= chip_reset_pin_low;
      slp_pin_d_r <= sleep_pin_low;
    end
  end

  // Entry delay picked by request kind and oscillator state
  always_comb begin
    entry_cyc = is_reset_r ? rsgc_pkg::CNT_W'(rsgc_pkg::RST_RET_CYC)
                           : rsgc_pkg::CNT_W'(rsgc_pkg::SLP_RET_CYC);
    if (!oscillator_on) begin
      entry_cyc = entry_cyc
                  + rsgc_pkg::CNT_W'(rsgc_pkg::OSC_SETTLE_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // State walk: off, exit, functional, clock stop, retention, exit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= rsgc_pkg::ST_OFF;
      cnt_r <= '0;
      slow_cnt_r <= '0;
      is_reset_r <= 1'b0;
    end else begin
      case (state_r)
        rsgc_pkg::ST_OFF: begin
          cnt_r <= '0;
          if (chip_reset_pin_low) begin
            state_r <= rsgc_pkg::ST_EXIT;
            is_reset_r <= 1'b1;
          end
        end
        rsgc_pkg::ST_FUNC: begin
          cnt_r <= '0;
          slow_cnt_r <= '0;
          if (rst_req || slp_req) begin
            state_r <= rsgc_pkg::ST_STOP;
            is_reset_r <= rst_req;
          end
        end
        rsgc_pkg::ST_STOP: begin
          cnt_r <= cnt_r + 1'b1;
          if (slow_clk_used && slow_clk_tick && slow_cnt_r != 2'h2) begin
            slow_cnt_r <= slow_cnt_r + 1'b1;
          end
          if (cnt_r + 1'b1 >= entry_cyc
              && (!slow_clk_used
                  || slow_cnt_r >= 2'(rsgc_pkg::SLOW_CLK_PERIODS)
                  || cnt_r + 1'b1
                     >= rsgc_pkg::CNT_W'(rsgc_pkg::CLK_STOP_CYC))) begin
            state_r <= rsgc_pkg::ST_RET;
            cnt_r <= '0;
          end
        end
        rsgc_pkg::ST_RET: begin
          cnt_r <= '0;
          if (is_reset_r && chip_reset_pin_low) begin
            state_r <= rsgc_pkg::ST_EXIT;
          end else if (!is_reset_r && sleep_pin_low
                       && !fabric_sleep_req) begin
            state_r <= rsgc_pkg::ST_EXIT;
          end
        end
        rsgc_pkg::ST_EXIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (is_reset_r && !chip_reset_pin_low) begin
            state_r <= rsgc_pkg::ST_RET;
            cnt_r <= '0;
          end else if (!is_reset_r && !sleep_pin_low) begin
            state_r <= rsgc_pkg::ST_RET;
            cnt_r <= '0;
          end else if (cnt_r + 1'b1 >= (is_reset_r
                ? rsgc_pkg::CNT_W'(rsgc_pkg::RST_EXIT_CYC)
                : rsgc_pkg::CNT_W'(rsgc_pkg::SLP_EXIT_CYC))) begin
            state_r <= rsgc_pkg::ST_FUNC;
            cnt_r <= '0;
          end
        end
        default: state_r <= rsgc_pkg::ST_OFF;
      endcase
    end
  end

  // Status outputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      retention_r <= 1'b1;
      user_clk_en_r <= 1'b0;
      config_start_r <= 1'b0;
      functional_r <= 1'b0;
    end else begin
      retention_r <= (state_r != rsgc_pkg::ST_FUNC);
      user_clk_en_r <= (state_r == rsgc_pkg::ST_FUNC)
                       && !rst_req && !slp_req;
      config_start_r <= (state_r == rsgc_pkg::ST_EXIT) && is_reset_r
        && cnt_r + 1'b1 >= rsgc_pkg::CNT_W'(rsgc_pkg::RST_EXIT_CYC)
        && chip_reset_pin_low;
      functional_r <= (state_r == rsgc_pkg::ST_FUNC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pads

  // Per-pad freeze, high impedance before first power-on exit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      output_pads_r <= '0;
      output_pads_oe_n_r <= '1;
    end else if (state_r == rsgc_pkg::ST_FUNC) begin
      output_pads_r <= user_out;
      output_pads_oe_n_r <= user_oe_n;
    end else if (state_r == rsgc_pkg::ST_OFF) begin
      output_pads_oe_n_r <= '1;
    end
  end

  // Static configuration decoders
  genvar gi;
  generate
    for (gi = 0; gi < rsgc_pkg::NUM_PADS; gi++) begin : g_pad
      rsgc_pad_decode u_dec (
        .mclk(mclk),
        .reset_n(reset_n),
        .cfg_load(cfg_load),
        .cfg_in(pin_cfg[gi]),
        .ctl_r(pad_ctl_r[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence entry_req_s;
    state_r == rsgc_pkg::ST_FUNC && (rst_req || slp_req);
  endsequence

  clk_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    entry_req_s |=> !user_clk_en_r)
    else $error("user clock not stopped");

  ret_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    entry_req_s |-> ##[1:502] state_r == rsgc_pkg::ST_RET)
    else $error("retention not reached within clock stop limit");

  rst_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
    entry_req_s ##0 rst_req && oscillator_on && !slow_clk_used
    |-> ##[29:30] state_r == rsgc_pkg::ST_RET)
    else $error("reset retention timing wrong");

  slp_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
    entry_req_s ##0 !rst_req && oscillator_on && !slow_clk_used
    |-> ##[4:5] state_r == rsgc_pkg::ST_RET)
    else $error("sleep retention timing wrong");

  fabric_rst_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == rsgc_pkg::ST_FUNC && fabric_reset_req
    |=> state_r == rsgc_pkg::ST_STOP && is_reset_r)
    else $error("fabric reset not taken");

  fabric_slp_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == rsgc_pkg::ST_FUNC && fabric_sleep_req && !rst_req
    |=> state_r == rsgc_pkg::ST_STOP && !is_reset_r)
    else $error("fabric sleep not taken");

  osc_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    entry_req_s ##0 !oscillator_on |=> state_r != rsgc_pkg::ST_RET [*8])
    else $error("oscillator settle time not added");

  hold_ret_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(state_r) == rsgc_pkg::ST_RET && state_r == rsgc_pkg::ST_RET
    |-> $stable(output_pads_r) && $stable(output_pads_oe_n_r))
    else $error("pads moved in retention");

  hiz_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(state_r) == rsgc_pkg::ST_OFF |-> &output_pads_oe_n_r)
    else $error("pad driven before power-on release");

  func_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == rsgc_pkg::ST_FUNC |=> output_pads_r == $past(user_out))
    else $error("pad value not following user logic");

  // Cycles spent in a sleep exit, kept apart from the sequencer count
  logic [rsgc_pkg::CNT_W-1:0] slp_exit_cnt_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slp_exit_cnt_r <= '0;
    end else if (state_r == rsgc_pkg::ST_EXIT && !is_reset_r) begin
      slp_exit_cnt_r <= slp_exit_cnt_r + 1'b1;
    end else begin
      slp_exit_cnt_r <= '0;
    end
  end

  exit_func_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == rsgc_pkg::ST_EXIT && !is_reset_r
    |-> slp_exit_cnt_r < rsgc_pkg::CNT_W'(rsgc_pkg::SLP_EXIT_CYC))
    else $error("sleep exit too slow");

endmodule : rsgc_seq

// >>> testbench/rsgc_host_model.sv
// Host model that drives the reset and sleep pins of the sequencer
`timescale 1ns/1ns
module rsgc_host_model #(
  parameter int LOW_CYC = rsgc_pkg::PIN_LOW_MIN_NS / rsgc_pkg::CLK_PERIOD_NS
) (
  input wire logic mclk,
  output logic chip_reset_pin_low,
  output logic sleep_pin_low
);
  int low_cnt = 0;
  // Both pins idle released
  initial begin
    chip_reset_pin_low = 1'h1;
    sleep_pin_low = 1'h1;
  end
  // Cycles spent with either pin held low
  always @(posedge mclk) begin
    low_cnt <= (chip_reset_pin_low & sleep_pin_low) ? 0 : low_cnt + 1;
  end
  // Pull one pin low, called just after an edge
  task automatic fall(input bit rst);
    if (rst) chip_reset_pin_low = 1'h0;
    else sleep_pin_low = 1'h0;
  endtask : fall
  // Release only once the least low time has run out
  task automatic rise(input bit rst);
    while (low_cnt < LOW_CYC) @(posedge mclk);
    #1;
    if (rst) chip_reset_pin_low = 1'h1;
    else sleep_pin_low = 1'h1;
  endtask : rise
endmodule : rsgc_host_model

// >>> testbench/tb_top.sv
// Self-checking bench for the reset and sleep sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  errors++; end end
module tb_top;
  localparam int NP = rsgc_pkg::NUM_PADS;
  localparam int SX = rsgc_pkg::SLP_EXIT_CYC;
  localparam int RX = rsgc_pkg::RST_EXIT_CYC;
  // Short low phase: the sequencer does not time it
  localparam int LOWC = 1000;
  // Fabric sleep exit as seen after the long clock stop wait
  localparam int FX = SX + rsgc_pkg::SLP_RET_CYC
    + rsgc_pkg::OSC_SETTLE_CYC - rsgc_pkg::CLK_STOP_CYC - 20;
  logic mclk, reset_n, frst, fslp, osc, tick, slow, cfg_load;
  rsgc_pkg::rsgc_pin_cfg_t cfg [NP];
  rsgc_pkg::rsgc_pad_ctl_t ctl [NP];
  logic [NP-1:0] uo, uoe_n, pads, pads_oe_n, held;
  logic rpin, spin, ret, clk_en, cfg_start, func;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, slow tick and run limit
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    tick <= (cyc % 8 == 0);
    if (cyc == 90000) begin
      errors++;
      conclude();
    end
  end
  rsgc_host_model #(.LOW_CYC(LOWC)) host (.mclk(mclk),
    .chip_reset_pin_low(rpin), .sleep_pin_low(spin));
  rsgc_seq dut (.mclk(mclk), .reset_n(reset_n), .chip_reset_pin_low(rpin),
    .sleep_pin_low(spin), .fabric_reset_req(frst), .fabric_sleep_req(fslp),
    .oscillator_on(osc), .slow_clk_tick(tick), .slow_clk_used(slow),
    .cfg_load(cfg_load), .pin_cfg(cfg), .user_out(uo), .user_oe_n(uoe_n),
    .output_pads_r(pads), .output_pads_oe_n_r(pads_oe_n), .pad_ctl_r(ctl),
    .retention_r(ret), .user_clk_en_r(clk_en), .config_start_r(cfg_start),
    .functional_r(func));
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  function automatic rsgc_pkg::rsgc_pad_ctl_t ex(input int i);
    logic [3:0] b;
    b = i[3:0];
    ex = {b[3], b[2], b[1] & ~b[0], b[1] & b[0]};
  endfunction : ex
  // Wait for functional state inside a cycle window
  task automatic wait_func(input int lo, input int hi, input bit cfgx);
    int n;
    bit seen;
    n = 0;
    seen = 1'h0;
    while (func !== 1'h1 && n <= hi) begin
      step(1);
      n++;
      if (cfg_start === 1'h1) seen = 1'h1;
    end
    `CHK(n >= lo && n <= hi, 1'h1)
    `CHK(seen, cfgx)
  endtask : wait_func
  task automatic load(input bit inv);
    for (int i = 0; i < NP; i++) cfg[i] = inv ? ~i[3:0] : i[3:0];
    cfg_load = 1'h1;
    step(1);
    cfg_load = 1'h0;
  endtask : load
  task automatic chk_ctl();
    for (int i = 0; i < NP; i++) `CHK(ctl[i], ex(i))
  endtask : chk_ctl
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_por();
    step(16);
    `CHK(pads_oe_n, {NP{1'h1}})
    `CHK({ret, clk_en, func}, 3'h4)
    reset_n = 1'h1;
    step(2);
    `CHK(pads_oe_n, {NP{1'h1}})
    load(1'h0);
    wait_func(RX - 3, RX + 3, 1'h1);
    chk_ctl();
    load(1'h1);
    step(3);
    chk_ctl();
  endtask : t_por
  task automatic t_user(input logic [NP-1:0] v, input logic [NP-1:0] e);
    uo = v;
    uoe_n = e;
    step(3);
    `CHK({pads, pads_oe_n}, {v, e})
    `CHK({ret, clk_en, func}, 3'h3)
  endtask : t_user
  task automatic t_sleep();
    held = pads;
    host.fall(1'h0);
    step(rsgc_pkg::SLP_RET_CYC + 2);
    `CHK({ret, clk_en, func}, 3'h4)
    t_user_hold();
    host.rise(1'h0);
    wait_func(SX - 3, SX + 3, 1'h0);
    t_user(19'h7_0F0F, 19'h0_5555);
  endtask : t_sleep
  // Pads keep their entry values while user logic moves on
  task automatic t_user_hold();
    uo = ~uo;
    uoe_n = ~uoe_n;
    step(3);
    `CHK({pads, pads_oe_n}, {held, ~uoe_n})
  endtask : t_user_hold
  task automatic t_fsleep();
    osc = 1'h0;
    slow = 1'h1;
    held = pads;
    fslp = 1'h1;
    step(1);
    fslp = 1'h0;
    step(rsgc_pkg::CLK_STOP_CYC + 20);
    `CHK({ret, clk_en, func}, 3'h4)
    `CHK(pads, held)
    osc = 1'h1;
    slow = 1'h0;
    wait_func(FX - 3, FX + 3, 1'h0);
  endtask : t_fsleep
  task automatic t_rpin();
    t_user(19'h2_3C3C, 19'h5_0A0A);
    host.fall(1'h1);
    step(rsgc_pkg::RST_RET_CYC + 2);
    `CHK({ret, clk_en, func}, 3'h4)
    `CHK({pads, pads_oe_n}, {19'h2_3C3C, 19'h5_0A0A})
    host.rise(1'h1);
    wait_func(RX - 3, RX + 3, 1'h1);
  endtask : t_rpin
  // Fabric reset request enters retention like the pin does
  task automatic t_frst();
    held = pads;
    frst = 1'h1;
    step(1);
    frst = 1'h0;
    uo = ~uo;
    step(rsgc_pkg::RST_RET_CYC + 2);
    `CHK({ret, clk_en, func}, 3'h4)
    `CHK({pads, pads_oe_n}, {held, 19'h5_0A0A})
  endtask : t_frst
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    reset_n = 1'h0;
    {frst, fslp, slow, cfg_load} = 4'h0;
    osc = 1'h1;
    uo = 19'h0_0000;
    uoe_n = {NP{1'h1}};
    for (int i = 0; i < NP; i++) cfg[i] = i[3:0];
    t_por();
    t_user(19'h5_A5A5, 19'h0_F0F0);
    t_sleep();
    t_fsleep();
    t_rpin();
    t_frst();
    conclude();
  end
endmodule : tb_top
